// ---- verilog/ics_pkg.sv ----
// constants, field layouts and state codes for the channel sequencer
// assumes a single 40 MHz clock shared by every module that imports it
package ics_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 25;
  localparam int SEL_STOR_NS   = 1500;
  localparam int SEL_STOR_CYC  = (SEL_STOR_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEL_END_STEPS = 3;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int SUB_SMALL  = 32;
  localparam int SUB_STD    = 96;
  localparam int SUB_EXT    = 224;
  localparam int MAX_CTRL   = 8;
  localparam int REC_BYTES  = 8;
  localparam int REC_W      = REC_BYTES * 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [1:0] CFG_SMALL  = 2'h0;
  localparam logic [1:0] CFG_STD    = 2'h1;
  localparam logic [1:0] CFG_EXT    = 2'h2;
  localparam logic [7:0] SHARE_MASK = 8'hf8;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  localparam int REC_ADDR_LSB  = 0;
  localparam int REC_CNT_LSB   = 16;
  localparam int REC_UNIT_LSB  = 32;
  localparam int REQ_DATA_LSB  = 0;
  localparam int REQ_SUB_LSB   = 8;
  localparam int REQ_BURST_BIT = 16;
  localparam int REQ_W         = 17;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_FETCH = 6'h02,
    M_LOAD  = 6'h04,
    M_XFER  = 6'h08,
    M_STORE = 6'h10,
    M_REST  = 6'h20
  } ics_mpx_state_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ACT  = 4'h2,
    S_MOVE = 4'h4,
    S_END  = 4'h8
  } ics_sel_state_t;

endpackage

// ---- verilog/ics_fifo_if.sv ----
// valid/ready word carrier between the queue and the sequencer
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface ics_fifo_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // ics_fifo_if

// ---- verilog/ics_fifo.sv ----
// request queue holding service requests in arrival order
// assumes DEPTH is a power of two; reset is asynchronous active low
`timescale 1ns/100ps
module ics_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  ics_fifo_if.src           out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out.valid && out.ready;
  assign out.valid = (cnt_reg != '0);
  assign out.data  = mem[rp_reg];

  always_comb begin
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // ---------------------------------------------------------------
  // pointers and level
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg   <= '0;
      rp_reg   <= '0;
      cnt_reg  <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg  <= cnt_next;
      in_ready <= (cnt_next != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp_reg] <= in_data;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_fifo_full_stall: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cnt_reg == (AW+1)'(DEPTH)) |-> !in_ready)
    else $error("queue full but still accepting");

  chk_fifo_no_wrap: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cnt_reg == (AW+1)'(DEPTH)) && !pop |=> (cnt_reg == $past(cnt_reg)))
    else $error("queue level moved past its depth");

endmodule // ics_fifo

// ---- verilog/ics_rec_mem.sv ----
// channel control area: one control record per subchannel
// assumes one write and one registered read per clock
`timescale 1ns/100ps
module ics_rec_mem #(
  parameter int W     = 64,
  parameter int DEPTH = 224,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en && (int'(wr_idx) < DEPTH)) mem[wr_idx] <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= (int'(rd_idx) < DEPTH) ? mem[rd_idx] : '0;
    end
  end
endmodule // ics_rec_mem

// ---- verilog/ics_seq.sv ----
// channel service sequencer: byte-interleaving channel plus one record
// channel, both borrowing the processor's control circuitry
// assumes all inputs are synchronous to ref_clk
//
// Behaviour
// - interleaved units are served byte by byte in arrival order
// - a burst unit keeps the channel until its whole record ends
// - while a burst unit runs, other units' bytes are refused
// - record channel serves exactly one unit at a time
// - record channel frees only after record end without chaining
// - processor is halted during every interleaved transfer step
// - save processor state, then fetch the subchannel's record
// - update record, write it back, restore state, resume
// - a pending request is served before restoring processor state
// - a byte offered while the queue cannot take it is lost
// - 32, 96 or 224 records; shared mode off with CFG_EXT
// - shared record serves one unit of its group at a time
// - record transfer pauses processor only for the byte move and ending steps
// - record channel times storage with its own cycle counter
// - record channel holds its single current record locally
// - chaining and ending save and restore processor state
// - record channel units carry an eight-bit unit address
// - each control record is eight bytes wide
`timescale 1ns/100ps
module ics_seq
  import ics_pkg::*;
#(
  parameter int DEPTH    = SUB_EXT,
  parameter int FIFO_D   = FIFO_DEPTH,
  parameter int STOR_CYC = SEL_STOR_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [1:0]       cfg_size,
  input  wire logic             cfg_shared,
  input  wire logic             mpx_req_valid,
  input  wire logic [7:0]       mpx_req_sub,
  input  wire logic [7:0]       mpx_req_data,
  input  wire logic             mpx_req_burst,
  output logic                  mpx_req_ready,
  output logic                  mpx_overrun,
  output logic                  mpx_reject,
  output logic                  mpx_burst,
  output logic                  mpx_wr_en,
  output logic      [15:0]      mpx_wr_addr,
  output logic      [7:0]       mpx_wr_data,
  input  wire logic             rec_wr_valid,
  input  wire logic [7:0]       rec_wr_idx,
  input  wire logic [REC_W-1:0] rec_wr_data,
  output logic                  rec_wr_ready,
  input  wire logic             sel_start_valid,
  input  wire logic [7:0]       sel_start_unit,
  input  wire logic [15:0]      sel_start_addr,
  input  wire logic [15:0]      sel_start_count,
  input  wire logic             sel_start_chain,
  input  wire logic [15:0]      sel_chain_addr,
  input  wire logic [15:0]      sel_chain_count,
  output logic                  sel_start_ready,
  input  wire logic             sel_req_valid,
  input  wire logic [7:0]       sel_req_unit,
  input  wire logic [7:0]       sel_req_data,
  output logic                  sel_req_ready,
  output logic                  sel_refuse,
  output logic                  sel_wr_en,
  output logic      [15:0]      sel_wr_addr,
  output logic      [7:0]       sel_wr_data,
  output logic                  sel_done,
  output logic                  cpu_halt,
  output logic                  cpu_save,
  output logic                  cpu_restore
);
  localparam int TW = $clog2(STOR_CYC + 1);

  ics_mpx_state_t   mst_reg, mst_next;
  ics_sel_state_t   sst_reg, sst_next;
  logic [REQ_W-1:0] cur_reg;
  logic [REC_W-1:0] rec_reg, rec_rd;
  logic [7:0]       cur_sub, head_sub, owner_reg;
  logic             lock_reg, rej, sharing, mem_we, rec_take;
  logic [15:0]      cnt_dec;
  logic             overrun_reg, reject_reg, wr_en_reg;
  logic [15:0]      wr_addr_reg, sel_addr_reg, sel_cnt_reg;
  logic [7:0]       wr_data_reg, sel_unit_reg, sel_byte_reg;
  logic             rec_rdy_reg, halt_reg, save_reg, rest_reg;
  logic             s_start_rdy_reg, s_req_rdy_reg, s_refuse_reg;
  logic             s_wr_en_reg, s_done_reg, sel_chain_reg, sel_take;
  logic [15:0]      s_wr_addr_reg, s_caddr_reg, s_ccnt_reg;
  logic [7:0]       s_wr_data_reg;
  logic [TW-1:0]    tmr_reg;
  logic [1:0]       step_reg;
  logic             sel_go, end_last;

  ics_fifo_if #(.W(REQ_W)) q ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] sub_idx(input logic [7:0] s,
                                         input logic sh);
    return sh ? (s & SHARE_MASK) : s;
  endfunction

  function automatic int sub_limit(input logic [1:0] c);
    if (c == CFG_SMALL) return SUB_SMALL;
    else if (c == CFG_STD) return SUB_STD;
    else return SUB_EXT;
  endfunction

  assign sharing  = cfg_shared && (cfg_size != CFG_EXT);
  assign cur_sub  = cur_reg[REQ_SUB_LSB +: 8];
  assign head_sub = q.data[REQ_SUB_LSB +: 8];
  assign q.ready  = (mst_reg == M_FETCH);
  assign cnt_dec  = rec_reg[REC_CNT_LSB +: 16] - 16'h0001;
  assign rec_take = rec_wr_valid && rec_rdy_reg;
  assign mem_we   = (mst_reg == M_STORE) || rec_take;
  assign sel_take = (sst_reg == S_ACT) && sel_req_valid && s_req_rdy_reg;
  assign sel_go   = (mst_reg == M_IDLE);
  assign end_last = (step_reg == 2'(SEL_END_STEPS - 1));

  // ---------------------------------------------------------------
  // queue and control area
  // ---------------------------------------------------------------
  ics_fifo #(.W(REQ_W), .DEPTH(FIFO_D)) u_fifo (
    .clk      (ref_clk),
    .rst_n    (reset_n),
    .in_valid (mpx_req_valid),
    .in_data  ({mpx_req_burst, mpx_req_sub, mpx_req_data}),
    .in_ready (mpx_req_ready),
    .out      (q.src)
  );

  ics_rec_mem #(.W(REC_W), .DEPTH(DEPTH), .AW(8)) u_mem (
    .clk     (ref_clk),
    .rst_n   (reset_n),
    .wr_en   (mem_we),
    .wr_idx  ((mst_reg == M_STORE) ? sub_idx(cur_sub, sharing)
                                   : rec_wr_idx),
    .wr_data ((mst_reg == M_STORE) ? rec_reg : rec_wr_data),
    .rd_en   (q.ready),
    .rd_idx  (sub_idx(head_sub, sharing)),
    .rd_data (rec_rd)
  );

  // ---------------------------------------------------------------
  // interleaving channel sequence
  // ---------------------------------------------------------------
  always_comb begin
    rej = (int'(sub_idx(cur_sub, sharing)) >= sub_limit(cfg_size))
       || (lock_reg && (cur_sub != owner_reg))
       || (rec_rd[REC_CNT_LSB +: 16] == 16'h0000)
       || (sharing && (rec_rd[REC_UNIT_LSB +: 8] != cur_sub));
  end

  always_comb begin
    mst_next = mst_reg;
    case (mst_reg)
      M_IDLE:  if (q.valid && (sst_reg != S_END)) mst_next = M_FETCH;
      M_FETCH: mst_next = M_LOAD;
      M_LOAD: begin
        if (!rej) mst_next = M_XFER;
        else if (q.valid) mst_next = M_FETCH;
        else mst_next = M_REST;
      end
      M_XFER:  mst_next = M_STORE;
      M_STORE: mst_next = q.valid ? M_FETCH : M_REST;
      M_REST:  mst_next = M_IDLE;
      default: mst_next = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mst_reg <= M_IDLE;
      cur_reg <= '0;
    end else begin
      mst_reg <= mst_next;
      if (q.ready) cur_reg <= q.data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rec_reg <= '0;
    end else if (mst_reg == M_LOAD) begin
      rec_reg <= rec_rd;
    end else if (mst_reg == M_XFER) begin
      rec_reg[REC_ADDR_LSB +: 16] <= rec_reg[REC_ADDR_LSB +: 16] + 16'h0001;
      rec_reg[REC_CNT_LSB +: 16]  <= cnt_dec;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg  <= 1'b0;
      owner_reg <= '0;
    end else if (mst_reg == M_XFER && cur_reg[REQ_BURST_BIT]) begin
      lock_reg  <= (cnt_dec != 16'h0000);
      owner_reg <= cur_sub;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      reject_reg  <= 1'b0;
      overrun_reg <= 1'b0;
      rec_rdy_reg <= 1'b0;
    end else begin
      wr_en_reg   <= (mst_reg == M_XFER);
      if (mst_reg == M_XFER) begin
        wr_addr_reg <= rec_reg[REC_ADDR_LSB +: 16];
        wr_data_reg <= cur_reg[REQ_DATA_LSB +: 8];
      end
      reject_reg  <= (mst_reg == M_LOAD) && rej;
      overrun_reg <= mpx_req_valid && !mpx_req_ready;
      rec_rdy_reg <= (mst_next == M_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // record channel
  // ---------------------------------------------------------------
  always_comb begin
    sst_next = sst_reg;
    case (sst_reg)
      S_IDLE: if (sel_start_valid && s_start_rdy_reg) sst_next = S_ACT;
      S_ACT: begin
        if (sel_take && (sel_req_unit == sel_unit_reg)) begin
          sst_next = S_MOVE;
        end
      end
      S_MOVE: begin
        if (tmr_reg == '0) begin
          sst_next = (sel_cnt_reg == 16'h0001) ? S_END : S_ACT;
        end
      end
      S_END: if (end_last) sst_next = sel_chain_reg ? S_ACT : S_IDLE;
      default: sst_next = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sst_reg       <= S_IDLE;
      sel_unit_reg  <= '0;
      sel_addr_reg  <= '0;
      sel_cnt_reg   <= '0;
      sel_chain_reg <= 1'b0;
      s_caddr_reg   <= '0;
      s_ccnt_reg    <= '0;
      sel_byte_reg  <= '0;
      tmr_reg       <= '0;
      step_reg      <= '0;
    end else begin
      sst_reg <= sst_next;
      if (sst_reg == S_IDLE && sst_next == S_ACT) begin
        sel_unit_reg  <= sel_start_unit;
        sel_addr_reg  <= sel_start_addr;
        sel_cnt_reg   <= sel_start_count;
        sel_chain_reg <= sel_start_chain;
        s_caddr_reg   <= sel_chain_addr;
        s_ccnt_reg    <= sel_chain_count;
      end
      if (sst_reg == S_ACT && sst_next == S_MOVE) begin
        sel_byte_reg <= sel_req_data;
        tmr_reg      <= TW'(STOR_CYC - 1);
      end else if (sst_reg == S_MOVE) begin
        tmr_reg <= tmr_reg - 1'b1;
        if (tmr_reg == '0) begin
          sel_addr_reg <= sel_addr_reg + 16'h0001;
          sel_cnt_reg  <= sel_cnt_reg - 16'h0001;
        end
      end
      if (sst_reg == S_END) begin
        if (step_reg != 2'h0 || sel_go) step_reg <= step_reg + 2'h1;
        if (end_last) begin
          step_reg      <= 2'h0;
          sel_chain_reg <= 1'b0;
        end
        if (step_reg == 2'h1 && sel_chain_reg) begin
          sel_addr_reg  <= s_caddr_reg;
          sel_cnt_reg   <= s_ccnt_reg;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_start_rdy_reg <= 1'b0;
      s_req_rdy_reg   <= 1'b0;
      s_refuse_reg    <= 1'b0;
      s_wr_en_reg     <= 1'b0;
      s_wr_addr_reg   <= '0;
      s_wr_data_reg   <= '0;
      s_done_reg      <= 1'b0;
    end else begin
      s_start_rdy_reg <= (sst_next == S_IDLE);
      s_req_rdy_reg   <= (sst_next == S_ACT);
      s_refuse_reg    <= sel_take && (sel_req_unit != sel_unit_reg);
      s_wr_en_reg     <= (sst_reg == S_MOVE) && (tmr_reg == '0);
      if (sst_reg == S_MOVE && tmr_reg == '0) begin
        s_wr_addr_reg <= sel_addr_reg;
        s_wr_data_reg <= sel_byte_reg;
      end
      s_done_reg <= (sst_reg == S_END) && end_last && !sel_chain_reg;
    end
  end

  // ---------------------------------------------------------------
  // processor hold, save and restore
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_reg <= 1'b0;
      save_reg <= 1'b0;
      rest_reg <= 1'b0;
    end else begin
      halt_reg <= (mst_next != M_IDLE) || (sst_next == S_MOVE)
               || (sst_next == S_END);
      save_reg <= (mst_reg == M_IDLE && mst_next == M_FETCH)
               || (sst_reg == S_END && step_reg == 2'h0 && sel_go);
      rest_reg <= (mst_reg != M_REST && mst_next == M_REST)
               || (sst_reg == S_END && step_reg == 2'h1);
    end
  end

  assign mpx_overrun     = overrun_reg;
  assign mpx_reject      = reject_reg;
  assign mpx_burst       = lock_reg;
  assign mpx_wr_en       = wr_en_reg;
  assign mpx_wr_addr     = wr_addr_reg;
  assign mpx_wr_data     = wr_data_reg;
  assign rec_wr_ready    = rec_rdy_reg;
  assign sel_start_ready = s_start_rdy_reg;
  assign sel_req_ready   = s_req_rdy_reg;
  assign sel_refuse      = s_refuse_reg;
  assign sel_wr_en       = s_wr_en_reg;
  assign sel_wr_addr     = s_wr_addr_reg;
  assign sel_wr_data     = s_wr_data_reg;
  assign sel_done        = s_done_reg;
  assign cpu_halt        = halt_reg;
  assign cpu_save        = save_reg;
  assign cpu_restore     = rest_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_mpx_halt_held: assert property (
    (mst_reg != M_IDLE) |-> cpu_halt)
    else $error("processor running during channel step");

  chk_save_then_load: assert property (
    (mst_reg == M_IDLE && mst_next == M_FETCH)
    |=> cpu_save ##1 (mst_reg == M_LOAD))
    else $error("record fetched without state save");

  chk_xfer_writeback: assert property (
    (mst_reg == M_XFER) |=> mpx_wr_en && (mst_reg == M_STORE))
    else $error("byte moved without record write back");

  chk_pending_first: assert property (
    (mst_reg == M_STORE && q.valid)
    |=> (mst_reg == M_FETCH) && !cpu_restore)
    else $error("restore taken before pending request");

  chk_burst_owner: assert property (
    (mst_reg == M_XFER && $past(lock_reg)) |-> (cur_sub == owner_reg))
    else $error("other unit served during burst");

  chk_sub_limit: assert property (
    (mst_reg == M_XFER)
    |-> (int'(sub_idx(cur_sub, sharing)) < sub_limit(cfg_size)))
    else $error("subchannel beyond configured count");

  chk_overrun_flag: assert property (
    (mpx_req_valid && !mpx_req_ready) |=> mpx_overrun)
    else $error("lost byte not flagged");

  chk_sel_pause_only: assert property (
    (sst_reg == S_MOVE && mst_reg == M_IDLE) |-> cpu_halt && !cpu_save)
    else $error("record transfer saved state or ran processor");

  chk_sel_cycle_end: assert property (
    (sst_reg == S_MOVE && tmr_reg == '0) |=> sel_wr_en
    ##1 !sel_wr_en)
    else $error("record storage cycle mistimed");

  chk_sel_one_unit: assert property (
    (sel_take && sel_req_unit != sel_unit_reg)
    |=> sel_refuse && (sst_reg == S_ACT))
    else $error("foreign unit took record channel");

  chk_sel_end_save: assert property (
    (sst_reg == S_END && step_reg == 2'h1) |-> cpu_save
    ##1 cpu_restore)
    else $error("ending step without save and restore");

  cov_burst_lock: cover property (mst_reg == M_XFER && lock_reg);
  cov_back_to_back: cover property (mst_reg == M_STORE ##1
                                    mst_reg == M_FETCH);
  cov_sel_chain: cover property (sst_reg == S_END ##1 sst_reg == S_ACT);
  cov_mpx_reject: cover property (mpx_reject);

endmodule // ics_seq

// ---- tb/ics_ctrl_model.sv ----
// one attached controller offering bytes to the interleaving channel
// assumes ref_clk from the bench; drives at the falling edge
// assumes at most eight controllers share the cable
`timescale 1ns/100ps
module ics_ctrl_model (
  input  wire logic       clk,
  input  wire logic       ready,
  output logic            valid,
  output logic      [7:0] sub,
  output logic      [7:0] data,
  output logic            burst
);
  initial begin
    valid = 1'b0; sub = 8'h00; data = 8'h00; burst = 1'b0;
  end
  // byte held until taken
  task automatic offer(input logic [7:0] s, d, input logic b);
    @(negedge clk);
    valid = 1'b1; sub = s; data = d; burst = b;
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    valid = 1'b0; sub = ~s; data = ~d;
  endtask
endmodule // ics_ctrl_model

// ---- tb/ics_seq_bench.sv ----
// bench for the channel service sequencer
// assumes ics_ctrl_model as the far-side controller
`timescale 1ns/100ps
module ics_seq_bench;
  import ics_pkg::*;
  logic ref_clk = 0, reset_n = 0, rv = 0, sv = 0, qv = 0;
  logic sch = 0, sh = 0;
  logic [1:0] cfg_size = 2'h1;
  logic [7:0] ri = 8'h00, su = 8'h00, qu = 8'h00, qd = 8'h00;
  logic [REC_W-1:0] rd = '0;
  logic [15:0] sa = 16'h0000, sc = 16'h0000, m_wa, s_wa;
  logic mv, mb, m_rdy, m_ovr, m_rej, m_bst, m_we, r_rdy, s_rdy, q_rdy;
  logic s_ref, s_we, s_done, halt, save, rest;
  logic [7:0] ms, md, m_wd, s_wd;
  int failures = 0, checks_done = 0, n;
  ics_seq #(.STOR_CYC(4)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfg_size(cfg_size), .cfg_shared(sh), .mpx_req_valid(mv),
    .mpx_req_sub(ms), .mpx_req_data(md), .mpx_req_burst(mb),
    .mpx_req_ready(m_rdy), .mpx_overrun(m_ovr), .mpx_reject(m_rej),
    .mpx_burst(m_bst), .mpx_wr_en(m_we), .mpx_wr_addr(m_wa),
    .mpx_wr_data(m_wd), .rec_wr_valid(rv), .rec_wr_idx(ri),
    .rec_wr_data(rd), .rec_wr_ready(r_rdy), .sel_start_valid(sv),
    .sel_start_unit(su), .sel_start_addr(sa), .sel_start_count(sc),
    .sel_start_chain(sch), .sel_chain_addr(16'h0300),
    .sel_chain_count(16'h0001), .sel_start_ready(s_rdy),
    .sel_req_valid(qv), .sel_req_unit(qu), .sel_req_data(qd),
    .sel_req_ready(q_rdy), .sel_refuse(s_ref), .sel_wr_en(s_we),
    .sel_wr_addr(s_wa), .sel_wr_data(s_wd), .sel_done(s_done),
    .cpu_halt(halt), .cpu_save(save), .cpu_restore(rest));
  ics_ctrl_model ctl (.clk(ref_clk), .ready(m_rdy), .valid(mv),
    .sub(ms), .data(md), .burst(mb));
  initial forever #12.5 ref_clk = ~ref_clk;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hs(input int k);
    logic [2:0] r;
    @(negedge ref_clk);
    if (k == 0) rv = 1'b1; else if (k == 1) sv = 1'b1; else qv = 1'b1;
    r = {q_rdy, s_rdy, r_rdy};
    while (r[k] !== 1'b1) begin
      @(negedge ref_clk);
      r = {q_rdy, s_rdy, r_rdy};
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    rv = 1'b0; sv = 1'b0; qv = 1'b0; qd = ~qd;
  endtask
  task automatic wait_ev(input int k, output int c);
    logic [4:0] ev;
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
      ev = {s_done, s_we, s_ref, m_rej, m_we};
    end while (ev[k] !== 1'b1 && c < 80);
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_mpx;
    ri = 8'h05; rd = {24'h0, 8'h05, 16'h0002, 16'h0100};
    hs(0);
    ctl.offer(8'h05, 8'ha5, 1'b0);
    wait_ev(0, n);
    chk(16'(n), 16'h0004);
    chk(m_wa, 16'h0100);
    chk({8'h00, m_wd}, 16'h00a5);
    @(negedge ref_clk);
    chk({15'h0, rest}, 16'h0001);
    ctl.offer(8'h05, 8'h3c, 1'b0);
    @(negedge ref_clk);
    chk({15'h0, save}, 16'h0001);
    wait_ev(0, n);
    chk(m_wa, 16'h0101);
    chk({15'h0, halt}, 16'h0001);
  endtask
  task automatic t_limit;
    cfg_size = 2'h0;
    ctl.offer(8'h28, 8'h11, 1'b0);
    wait_ev(1, n);
    chk(16'(n), 16'h0003);
    cfg_size = 2'h1;
  endtask
  // burst unit holds the channel; another unit's byte is rejected until its record ends
  task automatic t_burst;
    ri = 8'h06; rd = {24'h0, 8'h06, 16'h0002, 16'h0500};
    hs(0);
    ri = 8'h07; rd = {24'h0, 8'h07, 16'h0001, 16'h0600};
    hs(0);
    ctl.offer(8'h06, 8'hb1, 1'b1);
    wait_ev(0, n);
    chk({15'h0, m_bst}, 16'h0001);
    ctl.offer(8'h07, 8'hc2, 1'b0);
    wait_ev(1, n);
    chk(16'(n), 16'h0003);
    ctl.offer(8'h06, 8'hb2, 1'b1);
    wait_ev(0, n);
    chk(m_wa, 16'h0501);
    chk({15'h0, m_bst}, 16'h0000);
  endtask
  task automatic t_share;
    sh = 1'b1; ri = 8'h08; rd = {24'h0, 8'h0a, 16'h0001, 16'h0400};
    hs(0);
    ctl.offer(8'h0b, 8'h21, 1'b0);
    wait_ev(1, n);
    chk(16'(n), 16'h0003);
    ctl.offer(8'h0a, 8'h22, 1'b0);
    wait_ev(0, n);
    chk(m_wa, 16'h0400);
  endtask
  task automatic t_sel;
    su = 8'h03; sa = 16'h0200; sc = 16'h0001; sch = 1'b1;
    hs(1);
    qu = 8'h04;
    hs(2);
    chk({15'h0, s_ref}, 16'h0001);
    qu = 8'h03; qd = 8'h5a;
    hs(2);
    wait_ev(3, n);
    chk(16'(n), 16'h0004);
    chk(s_wa, 16'h0200);
    qd = 8'h6b;
    hs(2);
    wait_ev(3, n);
    chk(s_wa, 16'h0300);
    chk({8'h00, s_wd}, 16'h006b);
    wait_ev(4, n);
    chk(16'(n < 80), 16'h0001);
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_mpx();
    t_limit();
    t_burst();
    t_sel();
    t_share();
    tally_and_finish();
  end
endmodule // ics_seq_bench
